/* File: logic/bfs_pkg.sv */
// Package for the bridge fault supervisor: register map, flag bits, timing.
// Assumes a 40 MHz system clock and a plain strobed register port.
package bfs_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] STATUS_ADDR  = 8'h00;
    localparam logic [7:0] CLEAR_ADDR   = 8'h04;
    localparam logic [7:0] CTRL_ADDR    = 8'h08;
    localparam logic [7:0] IRQ_ST_ADDR  = 8'h0c;
    localparam logic [7:0] IRQ_MSK_ADDR = 8'h10;
    localparam logic [7:0] OUTST_ADDR   = 8'h14;

    // Flag bit positions, shared by status, clear, interrupt status and mask
    localparam int FLAG_W       = 12;
    localparam int THERM_SD_BIT = 0;
    localparam int THERM_WN_BIT = 1;
    localparam int CURR_BIT     = 2;
    localparam int OPEN_BIT     = 3;
    localparam int GND_A_BIT    = 4;
    localparam int GND_B_BIT    = 5;
    localparam int SUP_A_BIT    = 6;
    localparam int SUP_B_BIT    = 7;
    localparam int HIGH_BIT     = 8;
    localparam int LOW_BIT      = 9;
    localparam int PUMP_BIT     = 10;
    localparam int FRAME_BIT    = 11;

    // Control register fields
    localparam int CTRL_CLR_FLT_BIT = 0;  // Write-one pulse: fault-clear command
    localparam int CTRL_OL_REQ_BIT  = 1;  // Write-one pulse: open-load check request
    localparam int CTRL_HBRIDGE_BIT = 2;  // 1 = H-bridge mode, 0 = half-bridge
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

    // Mode codes
    typedef enum logic [1:0] {
        BFS_SLEEP   = 2'b00,
        BFS_STANDBY = 2'b01,
        BFS_NORMAL  = 2'b11
    } bfs_mode_t;

    // Output drive codes per half-bridge
    localparam logic [1:0] DRV_FOLLOW = 2'h0;
    localparam logic [1:0] DRV_HIGH   = 2'h1;
    localparam logic [1:0] DRV_HIZ    = 2'h2;

    // Timing: system clock and internal oscillator
    localparam int CLK_HZ      = 40_000_000;
    localparam int OSC_KHZ     = 9300;        // Nominal oscillator, 9.3 MHz
    localparam int PUMP_FILT_NS = 18000;      // Pump-low filter, 18.0 us
    // Pump filter counted in oscillator ticks, rounded up
    localparam int PUMP_FILT_TICKS = (PUMP_FILT_NS * OSC_KHZ + 999_999) / 1_000_000;
    localparam int TICK_ACC_W  = 16;
    // Phase accumulator step: 9.3 MHz out of 40 MHz, in 1/65536 units
    localparam int TICK_STEP   = (OSC_KHZ * 65536) / (CLK_HZ / 1000);
    // Spread spectrum: sweep counter width; step wobbles by up to 256 around nominal
    localparam int SPREAD_W    = 9;
endpackage

/* File: logic/bfs_supervisor.sv */
// Bridge fault supervisor: flag latching, clearing and output override.
// Assumes analog comparators on asynchronous pins and a synchronous host port.
// Behaviour
// - Thermal shutdown latches in normal mode; clear bit plus fault-clear restart.
// - Thermal warning is status only, auto clears, never in sleep.
// - Overcurrent latches in normal mode; clear bit, outputs never shut.
// - Open-load check on normal entry or request; info flag only.
// - Ground short flags per output latch; own clear, fault-clear restart.
// - Supply short flags per output latch; own clear, fault-clear restart.
// - Supply high/low detected outside sleep; outputs resume; flags need clear.
// - Pump-low flag after filter time, no action, auto clears.
// - Framing error flag outside sleep; cleared by clear bit.
// - Grounded output-buffer supply returns zero serial words; a floating one is not detected.
// - All filter timing from one internal 9.3 MHz oscillator tick.
// - Oscillator tick is frequency modulated; pump clock inherits it.
// - H-bridge supply high forces both outputs high; fault pin low.
// - Supply low tristates outputs; fault pin low until flags cleared.
// - Short or thermal shutdown latches outputs tristate until fault-clear.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module bfs_supervisor (
    input  wire logic              clk,
    input  wire logic              rstn,
    // Register port
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    // Device state
    input  wire logic [1:0]        mode,
    // Comparator pins
    input  wire logic              therm_sd_pin,
    input  wire logic              therm_wn_pin,
    input  wire logic              curr_pin,
    input  wire logic              open_pin,
    input  wire logic              gnd_a_pin,
    input  wire logic              gnd_b_pin,
    input  wire logic              sup_a_pin,
    input  wire logic              sup_b_pin,
    input  wire logic              high_pin,
    input  wire logic              low_pin,
    input  wire logic              pump_pin,
    input  wire logic              io_buffer_supply,
    // Pulse from the serial core on a bad transfer
    input  wire logic              frame_err,
    input  wire logic [15:0]       spi_word,
    // Outputs
    output logic      [15:0]       miso_word,
    output logic      [1:0]        drive_a,
    output logic      [1:0]        drive_b,
    output logic                   fault_pin_n,
    output logic                   pump_clk_en,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NPIN = 12;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    // Pin order matches the flag bit positions below, except bit 11 holds the buffer supply
    assign pin_raw = {io_buffer_supply, pump_pin, low_pin, high_pin, sup_b_pin, sup_a_pin,
                      gnd_b_pin, gnd_a_pin, open_pin, curr_pin, therm_wn_pin, therm_sd_pin};

    // Two flops per pin, first read only by second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal oscillator tick with spread spectrum
    logic [bfs_pkg::TICK_ACC_W-1:0] acc;
    logic [bfs_pkg::SPREAD_W-1:0]   tri_cnt;
    logic                           tri_up;
    logic [bfs_pkg::TICK_ACC_W:0]   acc_sum;
    logic [bfs_pkg::TICK_ACC_W-1:0] step;
    logic                           osc_tick;

    assign step = bfs_pkg::TICK_ACC_W'(bfs_pkg::TICK_STEP)
                  - bfs_pkg::TICK_ACC_W'(1 << (bfs_pkg::SPREAD_W - 1))
                  + bfs_pkg::TICK_ACC_W'(tri_cnt);
    assign acc_sum = {1'b0, acc} + {1'b0, step};

    // Carry out is the tick; the step stays below half, so ticks never touch
    // Single oscillator tick source
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc      <= '0;
            osc_tick <= 1'b0;
        end else begin
            acc      <= acc_sum[bfs_pkg::TICK_ACC_W-1:0];
            osc_tick <= acc_sum[bfs_pkg::TICK_ACC_W];
        end
    end

    // Sweep moves the step by a small fraction, well inside the oscillator tolerance
    // Triangle sweep advanced once per oscillator tick
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tri_cnt <= '0;
            tri_up  <= 1'b1;
        end else if (osc_tick) begin
            if (tri_up) begin
                tri_cnt <= tri_cnt + 1'b1;
                if (&tri_cnt[bfs_pkg::SPREAD_W-1:1]) tri_up <= 1'b0;
            end else begin
                tri_cnt <= tri_cnt - 1'b1;
                if (tri_cnt == bfs_pkg::SPREAD_W'(1)) tri_up <= 1'b1;
            end
        end
    end

    // Pump switching shares the modulated tick
    assign pump_clk_en = osc_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    logic awake;
    logic normal;
    logic normal_d;
    assign awake  = (mode != 2'(bfs_pkg::BFS_SLEEP));
    assign normal = (mode == 2'(bfs_pkg::BFS_NORMAL));

    // Code 10 counts as awake but never as normal
    // Previous-mode tracker for normal entry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) normal_d <= 1'b0;
        else       normal_d <= normal;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register strobes
    logic [31:0] ctrl;
    logic [bfs_pkg::FLAG_W-1:0] clr_req;
    logic clr_flt;
    logic ol_req;
    assign clr_req = (wr && addr == bfs_pkg::CLEAR_ADDR) ? wdata[bfs_pkg::FLAG_W-1:0] : '0;
    assign clr_flt = wr && addr == bfs_pkg::CTRL_ADDR && wdata[bfs_pkg::CTRL_CLR_FLT_BIT];
    assign ol_req  = wr && addr == bfs_pkg::CTRL_ADDR && wdata[bfs_pkg::CTRL_OL_REQ_BIT];

    // Control register, pulse bits do not stick
    // Pulse bits read back as zero, so software only sees the mode bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ctrl <= bfs_pkg::CTRL_RESET;
        else if (wr && addr == bfs_pkg::CTRL_ADDR) ctrl <= {29'h0, wdata[bfs_pkg::CTRL_HBRIDGE_BIT], 2'h0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detection qualifiers
    // Overcurrent latches its flag but never shuts the outputs
    logic [bfs_pkg::FLAG_W-1:0] det;
    logic pump_filt;
    logic open_window;
    assign open_window = (normal && !normal_d) || ol_req;

    // Shutdown and overcurrent faults in normal mode only; supply high/low and framing when awake
    always_comb begin
        det = '0;
        det[bfs_pkg::THERM_SD_BIT] = normal && sync2[0];
        det[bfs_pkg::CURR_BIT]     = normal && sync2[2];
        det[bfs_pkg::GND_A_BIT]    = normal && sync2[4];
        det[bfs_pkg::GND_B_BIT]    = normal && sync2[5];
        det[bfs_pkg::SUP_A_BIT]    = normal && sync2[6];
        det[bfs_pkg::SUP_B_BIT]    = normal && sync2[7];
        // Open load sampled at check time
        det[bfs_pkg::OPEN_BIT]     = open_window && sync2[3];
        det[bfs_pkg::HIGH_BIT]     = awake && sync2[8];
        det[bfs_pkg::LOW_BIT]      = awake && sync2[9];
        det[bfs_pkg::FRAME_BIT]    = awake && frame_err;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pump-low filter
    // A dip shorter than the filter time never reaches the flag
    logic [7:0] pump_cnt;

    // Counter on oscillator ticks, restarts on drop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pump_cnt  <= '0;
            pump_filt <= 1'b0;
        end else if (!(awake && sync2[10])) begin
            pump_cnt  <= '0;
            pump_filt <= 1'b0;
        end else if (osc_tick && !pump_filt) begin
            if (pump_cnt == 8'(bfs_pkg::PUMP_FILT_TICKS - 1)) pump_filt <= 1'b1;
            else pump_cnt <= pump_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags
    logic [bfs_pkg::FLAG_W-1:0] status;
    localparam logic [bfs_pkg::FLAG_W-1:0] AUTO_MASK =
        bfs_pkg::FLAG_W'((1 << bfs_pkg::THERM_WN_BIT) | (1 << bfs_pkg::PUMP_BIT));

    // Live flags ignore write-one clears; a held fault sets its flag again
    // Sticky flags per bit; set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < bfs_pkg::FLAG_W; gi++) begin : g_flag
            if (AUTO_MASK[gi]) begin : g_auto
                always_ff @(posedge clk or negedge rstn) begin
                    if (!rstn) status[gi] <= 1'b0;
                    else if (gi == bfs_pkg::THERM_WN_BIT) status[gi] <= awake && sync2[1];
                    else status[gi] <= pump_filt;
                end
            end else begin : g_latch
                always_ff @(posedge clk or negedge rstn) begin
                    if (!rstn) status[gi] <= 1'b0;
                    else if (det[gi]) status[gi] <= 1'b1;
                    else if (clr_req[gi]) status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Output shutdown latch
    logic off_latch;
    logic shut_cond;
    assign shut_cond = |{det[bfs_pkg::THERM_SD_BIT], det[bfs_pkg::GND_A_BIT], det[bfs_pkg::GND_B_BIT],
                         det[bfs_pkg::SUP_A_BIT], det[bfs_pkg::SUP_B_BIT]};
    logic latched_any;
    assign latched_any = |{status[bfs_pkg::THERM_SD_BIT], status[bfs_pkg::CURR_BIT],
                           status[bfs_pkg::GND_A_BIT], status[bfs_pkg::GND_B_BIT],
                           status[bfs_pkg::SUP_A_BIT], status[bfs_pkg::SUP_B_BIT]};

    // Fault-clear is refused while a shutdown, overcurrent or short flag is still set
    // Latched off until fault-clear with flags cleared
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) off_latch <= 1'b0;
        else if (shut_cond) off_latch <= 1'b1;
        // Restart needs clear bits then fault-clear
        else if (clr_flt && !latched_any) off_latch <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drive and fault pin
    logic [1:0] next_drive;
    logic       hbridge;
    assign hbridge = ctrl[bfs_pkg::CTRL_HBRIDGE_BIT];

    // Both halves move together; per-output control lies outside this block
    // Priority: shutdown, supply low, supply high
    always_comb begin
        next_drive = bfs_pkg::DRV_FOLLOW;
        if (off_latch || shut_cond) next_drive = bfs_pkg::DRV_HIZ;
        // Tristate while supply low, restore after
        else if (awake && sync2[9]) next_drive = bfs_pkg::DRV_HIZ;
        else if (awake && sync2[8] && hbridge) next_drive = bfs_pkg::DRV_HIGH;
        // Resume following inputs when condition ends
        else next_drive = bfs_pkg::DRV_FOLLOW;
    end

    // Fault pin follows the sticky flags, not the live comparator levels
    // Registered drive and fault pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_a     <= bfs_pkg::DRV_HIZ;
            drive_b     <= bfs_pkg::DRV_HIZ;
            fault_pin_n <= 1'b1;
        end else begin
            drive_a     <= next_drive;
            drive_b     <= next_drive;
            // Fault pin low until flags cleared
            fault_pin_n <= !(latched_any || status[bfs_pkg::HIGH_BIT] || status[bfs_pkg::LOW_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial data word
    // Blanking uses the synchronised level, so only a pin read low blanks the word; a floating pin is not detected
    // Zero word without output-buffer supply
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) miso_word <= '0;
        else if (!sync2[11]) miso_word <= '0;
        else miso_word <= spi_word;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    logic [bfs_pkg::FLAG_W-1:0] irq_st;
    logic [bfs_pkg::FLAG_W-1:0] irq_msk;
    logic [bfs_pkg::FLAG_W-1:0] status_d;

    // Edge detect keeps a standing flag from re-arming after a clear
    // Rising edge of any flag sets a sticky bit; set wins over clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_d <= '0;
            irq_st   <= '0;
        end else begin
            status_d <= status;
            irq_st   <= (status & ~status_d) |
                        (irq_st & ~((wr && addr == bfs_pkg::IRQ_ST_ADDR) ? wdata[bfs_pkg::FLAG_W-1:0] : '0));
        end
    end

    // Masked bits still collect events, so unmasking reports them at once
    // Mask register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) irq_msk <= '0;
        else if (wr && addr == bfs_pkg::IRQ_MSK_ADDR) irq_msk <= wdata[bfs_pkg::FLAG_W-1:0];
    end

    assign irq = |(irq_st & irq_msk);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    // Clear and unmapped addresses read as zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rdata <= '0;
        else if (rd) begin
            unique case (addr)
                bfs_pkg::STATUS_ADDR:  rdata <= {20'h0, status};
                bfs_pkg::CTRL_ADDR:    rdata <= ctrl;
                bfs_pkg::IRQ_ST_ADDR:  rdata <= {20'h0, irq_st};
                bfs_pkg::IRQ_MSK_ADDR: rdata <= {20'h0, irq_msk};
                bfs_pkg::OUTST_ADDR:   rdata <= {27'h0, off_latch, drive_b, drive_a};
                default:               rdata <= '0;
            endcase
        end else rdata <= '0;
    end

endmodule

/* File: sim/bfs_supervisor_asserts.sv */
// Checker on the supervisor ports: supply, short, serial and tick relations.
// Assumes software keeps H-bridge mode selected while faults are driven.
`timescale 1ns/100ps
module bfs_chk (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [1:0]  mode,
    input wire logic        therm_sd_pin,
    input wire logic        gnd_a_pin,
    input wire logic        gnd_b_pin,
    input wire logic        sup_a_pin,
    input wire logic        sup_b_pin,
    input wire logic        high_pin,
    input wire logic        low_pin,
    input wire logic        io_buffer_supply,
    input wire logic [15:0] miso_word,
    input wire logic [1:0]  drive_a,
    input wire logic [1:0]  drive_b,
    input wire logic        fault_pin_n,
    input wire logic        pump_clk_en
);
    logic up;
    logic sc;
    logic hz;
    logic hi;
    // Awake, shutdown fault in normal mode, both outputs off or forced high
    assign up = mode != 2'b00;
    assign sc = mode == 2'b11 && (therm_sd_pin || gnd_a_pin || gnd_b_pin || sup_a_pin || sup_b_pin);
    assign hz = drive_a == bfs_pkg::DRV_HIZ && drive_b == bfs_pkg::DRV_HIZ;
    assign hi = drive_a == bfs_pkg::DRV_HIGH && drive_b == bfs_pkg::DRV_HIGH;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    property p_miso; (!io_buffer_supply) [*4] |-> miso_word == 16'h0000; endproperty
    property p_lowz; (up && low_pin) [*4] |-> hz; endproperty
    property p_lowf; (up && low_pin) [*5] |-> !fault_pin_n; endproperty
    property p_high; (up && high_pin && !low_pin) [*4] |-> hi; endproperty
    property p_scz; sc [*4] |-> hz; endproperty
    property p_scf; sc [*5] |-> !fault_pin_n; endproperty
    property p_tick; pump_clk_en |=> !pump_clk_en; endproperty
    property p_gap; $fell(pump_clk_en) |-> ##[1:6] pump_clk_en; endproperty
    a_miso: assert property (p_miso) else $error("serial word not zero");
    a_lowz: assert property (p_lowz) else $error("outputs not off on supply low");
    a_lowf: assert property (p_lowf) else $error("fault pin high on supply low");
    a_high: assert property (p_high) else $error("outputs not high on supply high");
    a_scz: assert property (p_scz) else $error("outputs not off on short");
    a_scf: assert property (p_scf) else $error("fault pin high on short");
    a_tick: assert property (p_tick) else $error("tick longer than one cycle");
    a_gap: assert property (p_gap) else $error("tick gap too long");
    // Main scenarios reached
    c_low: cover property ((up && low_pin) [*5]);
    c_sc: cover property (sc [*5]);
    c_miso: cover property ((!io_buffer_supply) [*5]);
endmodule
bind bfs_supervisor bfs_chk u_chk (.*);

/* File: sim/bfs_host.sv */
// Host model: master on the supervisor register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/100ps
module bfs_host (
    input  wire logic        clk,
    input  wire logic [31:0] rdata,
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd
);
    // Idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One write cycle; data inverted once released
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // One read cycle, data taken in the following cycle
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic clear_restart(input logic [11:0] f);
        write_reg(bfs_pkg::CLEAR_ADDR, {20'h0, f});
        write_reg(bfs_pkg::CTRL_ADDR, 32'h5);
    endtask
endmodule

/* File: sim/test_bridge_fault_supervisor.sv */
// Testbench for the bridge fault supervisor with a host model on its registers.
// Assumes H-bridge mode stays set and comparator pins are plain levels.
`timescale 1ns/100ps
module test_bridge_fault_supervisor;
    localparam int LB [6] = '{0, 2, 4, 5, 6, 7};
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [1:0]  mode = 2'b01;
    logic [10:0] pins = 11'h0;
    logic        io_buffer_supply = 1'b1;
    logic        frame_err = 1'b0;
    logic [15:0] spi_word = 16'h5a3c;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic        wr;
    logic        rd;
    logic [15:0] miso_word;
    logic [1:0]  drive_a;
    logic [1:0]  drive_b;
    logic        fault_pin_n;
    logic        irq;
    int          errors = 0;
    int          checked = 0;
    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;
    // Register master and the block
    bfs_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    bfs_supervisor dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mode(mode),
        .therm_sd_pin(pins[0]), .therm_wn_pin(pins[1]), .curr_pin(pins[2]), .open_pin(pins[3]),
        .gnd_a_pin(pins[4]), .gnd_b_pin(pins[5]), .sup_a_pin(pins[6]), .sup_b_pin(pins[7]),
        .high_pin(pins[8]), .low_pin(pins[9]), .pump_pin(pins[10]), .io_buffer_supply(io_buffer_supply),
        .frame_err(frame_err), .spi_word(spi_word), .miso_word(miso_word), .drive_a(drive_a),
        .drive_b(drive_b), .fault_pin_n(fault_pin_n), .pump_clk_en(), .irq(irq)
    );
    ////////////////////////////////////////////////////////////
    // Compare, wait, status bit and clear helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic st(input int b, input logic e, input string n);
        host.read_reg(bfs_pkg::STATUS_ADDR, rv);
        chk(n, {31'h0, e}, {31'h0, rv[b]});
    endtask
    task automatic clr(input logic [31:0] m);
        host.write_reg(bfs_pkg::CLEAR_ADDR, m);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Reset values, read-only status, unmapped address
    task automatic t_reset;
        host.read_reg(bfs_pkg::CTRL_ADDR, rv);
        chk("ctrl reset", bfs_pkg::CTRL_RESET, rv);
        host.write_reg(bfs_pkg::STATUS_ADDR, 32'hfff);
        host.read_reg(bfs_pkg::STATUS_ADDR, rv);
        chk("status reset", 32'h0, rv);
        host.read_reg(8'h18, rv);
        chk("unmapped", 32'h0, rv);
        $display("test reset done");
    endtask
    // Supply high and low, recovery and flag clearing
    task automatic t_supply;
        mode <= 2'b11;
        pins[8] <= 1'b1;
        cyc(6);
        chk("high drive", bfs_pkg::DRV_HIGH, drive_a);
        pins[8] <= 1'b0;
        cyc(6);
        chk("high resume", bfs_pkg::DRV_FOLLOW, drive_b);
        chk("high pin held", 1'b0, fault_pin_n);
        st(8, 1'b1, "high flag");
        clr(32'h100);
        cyc(2);
        chk("high pin freed", 1'b1, fault_pin_n);
        pins[9] <= 1'b1;
        cyc(6);
        chk("low off", bfs_pkg::DRV_HIZ, drive_a);
        pins[9] <= 1'b0;
        cyc(6);
        chk("low resume", bfs_pkg::DRV_FOLLOW, drive_a);
        chk("low pin held", 1'b0, fault_pin_n);
        clr(32'h200);
        cyc(2);
        chk("low pin freed", 1'b1, fault_pin_n);
        mode <= 2'b00;
        pins[9] <= 1'b1;
        cyc(6);
        st(9, 1'b0, "low in sleep");
        pins[9] <= 1'b0;
        cyc(4);
        $display("test supply done");
    endtask
    // Latching faults: set beats clear, restart only after clearing
    task automatic t_latch;
        int b;
        logic [1:0] e;
        mode <= 2'b11;
        for (int i = 0; i < 6; i++) begin
            b = LB[i];
            e = (b == 2) ? bfs_pkg::DRV_FOLLOW : bfs_pkg::DRV_HIZ;
            pins[b] <= 1'b1;
            cyc(6);
            clr(32'h1 << b);
            st(b, 1'b1, "set beats clear");
            pins[b] <= 1'b0;
            cyc(6);
            st(b, 1'b1, "flag latched");
            chk("off held", e, drive_a);
            host.read_reg(bfs_pkg::OUTST_ADDR, rv);
            chk("out state", {27'h0, b != 2, e, e}, rv);
            host.write_reg(bfs_pkg::CTRL_ADDR, 32'h5);
            cyc(2);
            chk("restart refused", e, drive_b);
            host.clear_restart(12'h1 << b);
            st(b, 1'b0, "flag cleared");
            chk("restarted", bfs_pkg::DRV_FOLLOW, drive_a);
        end
        $display("test latch done");
    endtask
    // Pump filter restarts on a drop, then sets and clears itself
    task automatic t_pump;
        pins[10] <= 1'b1;
        cyc(600);
        pins[10] <= 1'b0;
        cyc(6);
        pins[10] <= 1'b1;
        cyc(600);
        st(10, 1'b0, "pump restart");
        cyc(300);
        st(10, 1'b1, "pump set");
        chk("pump no action", bfs_pkg::DRV_FOLLOW, drive_a);
        pins[10] <= 1'b0;
        cyc(4);
        st(10, 1'b0, "pump auto clear");
        $display("test pump done");
    endtask
    // Framing error awake and asleep
    task automatic t_frame;
        for (int s = 0; s < 2; s++) begin
            mode <= (s == 0) ? 2'b01 : 2'b00;
            frame_err <= 1'b1;
            cyc(1);
            frame_err <= 1'b0;
            cyc(2);
            st(11, s == 0, "frame flag");
            clr(32'h800);
            st(11, 1'b0, "frame cleared");
        end
        $display("test frame done");
    endtask
    // Open load on entry to normal and on request
    task automatic t_open;
        mode <= 2'b01;
        pins[3] <= 1'b1;
        cyc(4);
        st(3, 1'b0, "open in standby");
        mode <= 2'b11;
        cyc(3);
        st(3, 1'b1, "open on entry");
        chk("open no action", bfs_pkg::DRV_FOLLOW, drive_a);
        clr(32'h8);
        st(3, 1'b0, "open cleared");
        host.write_reg(bfs_pkg::CTRL_ADDR, 32'h6);
        st(3, 1'b1, "open on request");
        pins[3] <= 1'b0;
        clr(32'h8);
        $display("test open done");
    endtask
    // Serial word blanked without buffer supply, warning and interrupt
    task automatic t_warn;
        pins[1] <= 1'b1;
        io_buffer_supply <= 1'b0;
        host.write_reg(bfs_pkg::IRQ_ST_ADDR, 32'hfff);
        host.write_reg(bfs_pkg::IRQ_MSK_ADDR, 32'h0);
        chk("serial word", 16'h0000, miso_word);
        io_buffer_supply <= 1'b1;
        st(1, 1'b1, "warn flag");
        chk("warn no action", bfs_pkg::DRV_FOLLOW, drive_a);
        chk("irq masked", 1'b0, irq);
        host.write_reg(bfs_pkg::IRQ_MSK_ADDR, 32'h2);
        cyc(1);
        chk("irq raised", 1'b1, irq);
        chk("serial word live", 16'h5a3c, miso_word);
        host.write_reg(bfs_pkg::IRQ_ST_ADDR, 32'h2);
        cyc(1);
        chk("irq cleared", 1'b0, irq);
        clr(32'h2);
        st(1, 1'b1, "warn live");
        pins[1] <= 1'b0;
        cyc(4);
        st(1, 1'b0, "warn auto clear");
        mode <= 2'b00;
        pins[1] <= 1'b1;
        cyc(5);
        st(1, 1'b0, "warn in sleep");
        $display("test warn done");
    endtask
    ////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        report_and_stop;
    end
    // Reset, then every scenario in turn
    initial begin
        cyc(16);
        rstn <= 1'b1;
        cyc(2);
        t_reset;
        t_supply;
        t_latch;
        t_pump;
        t_frame;
        t_open;
        t_warn;
        report_and_stop;
    end
endmodule
